// File: rtl/cpu_address_generation.sv
/*
  Address generator: operand effective addresses and branch targets.
  Assumes the decoder presents one request per start pulse and the memory
  answers reads in the same cycle as mem_rd (mem_rdata valid then).
*/
`timescale 1ns/100ps
module cpu_address_generation (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic                 start,
  input  wire agen_pkg::mode_t      mode,
  input  wire logic [7:0]           opcode,
  input  wire logic [7:0]           short_field,
  input  wire logic [15:0]          full_address_field,
  input  wire logic [2:0]           byte_register_index,
  input  wire logic [1:0]           word_register_index,
  input  wire logic                 reg_write,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic [15:0]          next_ip,
  input  wire logic [7:0]           mem_rdata,
  output logic                      busy,
  output logic                      done,
  output logic [15:0]               eff_addr,
  output logic                      eff_valid,
  output logic                      sel_ram,
  output logic                      sel_sfr,
  output logic                      addr_fault,
  output logic [7:0]                reg_byte,
  output logic [15:0]               reg_word,
  output logic                      mem_rd,
  output logic [15:0]               mem_addr,
  output logic [15:0]               instruction_pointer,
  output logic [15:0]               stack_pointer
);
  typedef enum logic [1:0] {st_idle, st_lo, st_hi} fetch_t;

  fetch_t      state_reg;
  logic [15:0] entry_reg;
  logic [7:0]  lo_byte_reg;
  logic [15:0] ea_next;
  logic        fault_next;

  agen_regs_if rf ();

  gp_regfile u_regs (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .rf     (rf)
  );

  assign rf.byte_register_index = byte_register_index;
  assign rf.word_register_index = word_register_index;
  // a request during a table fetch is refused, register writes included
  assign rf.wr_en               = start && !busy && reg_write &&
                                  (mode == agen_pkg::mode_reg || mode == agen_pkg::mode_reg_pair);
  assign rf.wr_word             = (mode == agen_pkg::mode_reg_pair);
  assign rf.wr_data             = reg_wdata;

  function automatic logic [15:0] short_addr(input logic [7:0] f);
    // bit 8 comes from the range of the field so fe20h..ff1fh is contiguous
    short_addr = {agen_pkg::short_top_bits, (f <= agen_pkg::short_wrap_max), f};
  endfunction : short_addr

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= agen_pkg::ram_lo) && (a <= agen_pkg::ram_hi);
  endfunction : in_ram

  // effective address for the requested mode
  always_comb begin
    ea_next    = 16'h0000;
    fault_next = 1'b0;
    unique case (mode)
      agen_pkg::mode_direct:     ea_next = full_address_field;
      agen_pkg::mode_short:      ea_next = short_addr(short_field);
      agen_pkg::mode_short_word: begin
        ea_next    = short_addr(short_field);
        fault_next = short_field[0];
      end
      agen_pkg::mode_sfr: begin
        ea_next    = {agen_pkg::sfr_page, short_field};
        fault_next = (ea_next >= agen_pkg::sfr_gap_lo) && (ea_next <= agen_pkg::sfr_gap_hi);
      end
      agen_pkg::mode_ind_second: ea_next = rf.second_pointer_pair;
      agen_pkg::mode_ind_base:   ea_next = rf.base_pointer_pair;
      agen_pkg::mode_based:      ea_next = 16'(rf.base_pointer_pair + {8'h00, short_field});
      agen_pkg::mode_push: begin
        ea_next    = 16'(stack_pointer - 16'h0001);
        fault_next = !in_ram(ea_next);
      end
      agen_pkg::mode_pop: begin
        ea_next    = stack_pointer;
        fault_next = !in_ram(ea_next);
      end
      agen_pkg::mode_none, agen_pkg::mode_reg, agen_pkg::mode_reg_pair,
      agen_pkg::mode_table_call, agen_pkg::mode_reg_jump: ea_next = 16'h0000;
    endcase
  end

  // operand address output, registered one cycle after start
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eff_addr   <= 16'h0000;
      eff_valid  <= 1'b0;
      addr_fault <= 1'b0;
      sel_ram    <= 1'b0;
      sel_sfr    <= 1'b0;
    end else if (ce) begin
      eff_valid <= start && (state_reg == st_idle) && !(mode inside {agen_pkg::mode_none, agen_pkg::mode_reg,
                   agen_pkg::mode_reg_pair, agen_pkg::mode_table_call, agen_pkg::mode_reg_jump});
      if (start && state_reg == st_idle) begin
        eff_addr   <= ea_next;
        addr_fault <= fault_next;
        sel_ram    <= in_ram(ea_next);
        sel_sfr    <= ea_next >= agen_pkg::sfr_lo;
      end
    end
  end

  // register operands are combinational reads of the register file
  assign reg_byte = rf.byte_value;
  assign reg_word = rf.word_value;

  // stack pointer steps on push and pop; faulting accesses leave it alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stack_pointer <= agen_pkg::stack_reset;
    end else if (ce && start && state_reg == st_idle && !fault_next) begin
      if (mode == agen_pkg::mode_push) stack_pointer <= ea_next;
      else if (mode == agen_pkg::mode_pop) stack_pointer <= 16'(stack_pointer + 16'h0001);
    end
  end

  // table call: two byte reads from the table, then load the pointer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg   <= st_idle;
      entry_reg   <= agen_pkg::table_base;
      lo_byte_reg <= 8'h00;
    end else if (ce) begin
      unique case (state_reg)
        st_idle: if (start && mode == agen_pkg::mode_table_call) begin
          // even entry: bit 6 set, index in bits 5..1, bit 0 clear
          entry_reg <= {9'h000, 1'b1, opcode[agen_pkg::table_idx_msb:agen_pkg::table_idx_lsb], 1'b0};
          state_reg <= st_lo;
        end
        st_lo: begin
          lo_byte_reg <= mem_rdata;
          state_reg   <= st_hi;
        end
        st_hi: state_reg <= st_idle;
      endcase
    end
  end

  assign mem_rd   = (state_reg != st_idle) && ce;
  assign mem_addr = (state_reg == st_hi) ? (entry_reg | 16'h0001) : entry_reg;
  assign busy     = (state_reg != st_idle);

  // instruction pointer follows the decoder unless a branch forms a target
  always_ff @(posedge clk) begin
    if (!resetn) begin
      instruction_pointer <= agen_pkg::ip_reset;
      done                <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (state_reg == st_hi) begin
        instruction_pointer <= {mem_rdata, lo_byte_reg};
        done                <= 1'b1;
      end else if (start && state_reg == st_idle && mode == agen_pkg::mode_reg_jump) begin
        instruction_pointer <= rf.accumulator_pair;
        done                <= 1'b1;
      end else if (start && state_reg == st_idle && mode != agen_pkg::mode_table_call) begin
        instruction_pointer <= next_ip;
        done                <= 1'b1;
      end
    end
  end
endmodule : cpu_address_generation

// File: rtl/agen_pkg.sv
/*
  Constants, encodings and rule summary for the core's address generator.
  Assumes a 16-bit address space on an 8-bit core.
*/
// Function
// - table call indexes a table entry by instruction bits 1 to 5, loads target
// - branch table lives at 40h..7fh; target may be anywhere
// - register jump copies accumulator pair into instruction pointer
// - direct addressing uses the 16-bit field unchanged
// - short direct reaches 256-byte window fe20h..ff1fh from 8-bit field
// - bit 8 clear for field 20h..ffh, set for 00h..1fh
// - fe20h..feffh is fast ram, ff00h..ff1fh is special registers
// - word short direct accepts only even addresses
// - special-register field selects ff00h..ffcfh or ffe0h..ffffh, 240 bytes
// - ff00h..ff1fh same storage by special-register or short direct form
// - 3-bit code selects one of eight byte registers
// - eight byte registers and four pairs, same by function or index
// - register indirect uses second or base pointer pair as address
// - based addressing adds zero-extended 8-bit offset to base pointer pair
// - carry out of based sum discarded, address wraps
// - stack pointer addresses push, pop, call, return and interrupt saves; the code steps it for push and pop only
// - stack accesses must stay inside fast ram
package agen_pkg;
  localparam logic [15:0] table_base      = 16'h0040;
  localparam logic [15:0] table_last      = 16'h007f;
  localparam logic [15:0] short_lo        = 16'hfe20;
  localparam logic [15:0] short_hi        = 16'hff1f;
  localparam logic [15:0] ram_lo          = 16'hfe20;
  localparam logic [15:0] ram_hi          = 16'hfeff;
  localparam logic [15:0] sfr_lo          = 16'hff00;
  localparam logic [15:0] sfr_gap_lo      = 16'hffd0;
  localparam logic [15:0] sfr_gap_hi      = 16'hffdf;
  localparam logic [7:0]  short_wrap_max  = 8'h1f;
  localparam logic [6:0]  short_top_bits  = 7'h7f;
  localparam logic [7:0]  sfr_page        = 8'hff;
  localparam logic [15:0] ip_reset        = 16'h0000;
  localparam logic [15:0] stack_reset     = 16'hfeff;
  localparam int          table_idx_lsb   = 1;
  localparam int          table_idx_msb   = 5;
  localparam int          acc_pair_idx    = 0;
  localparam int          second_pair_idx = 2;
  localparam int          base_pair_idx   = 3;

  typedef enum logic [3:0] {
    mode_none, mode_direct, mode_short, mode_short_word, mode_sfr,
    mode_reg, mode_reg_pair, mode_ind_second, mode_ind_base, mode_based,
    mode_push, mode_pop, mode_table_call, mode_reg_jump
  } mode_t;
endpackage : agen_pkg

// File: rtl/agen_regs_if.sv
/*
  Bundle between the address generator and its register file.
  Assumes a single clock domain.
*/
`timescale 1ns/100ps
interface agen_regs_if;
  logic [2:0]  byte_register_index;
  logic [1:0]  word_register_index;
  logic [7:0]  byte_value;
  logic [15:0] word_value;
  logic [15:0] accumulator_pair;
  logic [15:0] second_pointer_pair;
  logic [15:0] base_pointer_pair;
  logic        wr_en;
  logic        wr_word;
  logic [15:0] wr_data;
  modport core (output byte_register_index, word_register_index, wr_en, wr_word, wr_data,
                input byte_value, word_value, accumulator_pair, second_pointer_pair, base_pointer_pair);
  modport file (input byte_register_index, word_register_index, wr_en, wr_word, wr_data,
                output byte_value, word_value, accumulator_pair, second_pointer_pair, base_pointer_pair);
endinterface : agen_regs_if

// File: rtl/gp_regfile.sv
/*
  Eight byte registers viewed also as four pairs.
  Assumes the core drives index and write strobes on the same clock.
*/
`timescale 1ns/100ps
module gp_regfile (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  agen_regs_if.file rf
);
  logic [7:0] regs_reg [8];

  // pairs are the same flops as byte registers, so both namings agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) regs_reg[i] <= 8'h00;
    end else if (ce && rf.wr_en) begin
      if (rf.wr_word) begin
        regs_reg[{rf.word_register_index, 1'b0}] <= rf.wr_data[7:0];
        regs_reg[{rf.word_register_index, 1'b1}] <= rf.wr_data[15:8];
      end else begin
        regs_reg[rf.byte_register_index] <= rf.wr_data[7:0];
      end
    end
  end

  assign rf.byte_value          = regs_reg[rf.byte_register_index];
  assign rf.word_value          = {regs_reg[{rf.word_register_index, 1'b1}],
                                   regs_reg[{rf.word_register_index, 1'b0}]};
  assign rf.accumulator_pair    = {regs_reg[2*agen_pkg::acc_pair_idx+1], regs_reg[2*agen_pkg::acc_pair_idx]};
  assign rf.second_pointer_pair = {regs_reg[2*agen_pkg::second_pair_idx+1], regs_reg[2*agen_pkg::second_pair_idx]};
  assign rf.base_pointer_pair   = {regs_reg[2*agen_pkg::base_pair_idx+1], regs_reg[2*agen_pkg::base_pair_idx]};
endmodule : gp_regfile

// File: testbench/cpu_address_generation_sva.sv
/* assertion checker for the address generator, bound to its top module.
   assumes one clock with synchronous active-low reset. */
`timescale 1ns/100ps
module cpu_address_generation_sva (
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic            ce,
  input wire logic            start,
  input wire agen_pkg::mode_t mode,
  input wire logic [7:0]      opcode,
  input wire logic [7:0]      short_field,
  input wire logic [15:0]     full_address_field,
  input wire logic [1:0]      word_register_index,
  input wire logic [7:0]      mem_rdata,
  input wire logic            busy,
  input wire logic            done,
  input wire logic [15:0]     eff_addr,
  input wire logic            eff_valid,
  input wire logic            addr_fault,
  input wire logic [15:0]     reg_word,
  input wire logic            mem_rd,
  input wire logic [15:0]     mem_addr,
  input wire logic [15:0]     instruction_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       take;
  logic [4:0] tix;
  logic [7:0] lo_reg;
  assign take = start && ce && !busy;
  assign tix  = opcode[5:1];
  // the low table byte is gone when the pointer loads, so keep it
  always_ff @(posedge clk) begin
    if (mem_rd && !mem_addr[0]) begin
      lo_reg <= mem_rdata;
    end
  end
  property p_direct; take && mode == agen_pkg::mode_direct |=> eff_valid && eff_addr == $past(full_address_field); endproperty
  a_direct: assert property (p_direct) else $error("direct address");
  property p_short; take && mode == agen_pkg::mode_short |=> eff_addr == {7'h7f, $past(short_field) < 8'h20, $past(short_field)}; endproperty
  a_short: assert property (p_short) else $error("short address");
  property p_sfr; take && mode == agen_pkg::mode_sfr |=> eff_addr == {8'hff, $past(short_field)} && addr_fault == (eff_addr[7:4] == 4'hd); endproperty
  a_sfr: assert property (p_sfr) else $error("sfr address");
  property p_word; take && mode == agen_pkg::mode_short_word |=> addr_fault == eff_addr[0] && eff_addr[15:9] == 7'h7f; endproperty
  a_word: assert property (p_word) else $error("word short");
  property p_based; take && mode == agen_pkg::mode_based && word_register_index == 2'd3 |=> eff_addr == 16'($past(reg_word) + $past(short_field)); endproperty
  a_based: assert property (p_based) else $error("based address");
  property p_jump; take && mode == agen_pkg::mode_reg_jump && word_register_index == 2'd0 |=> instruction_pointer == $past(reg_word); endproperty
  a_jump: assert property (p_jump) else $error("register jump");
  property p_tfetch; take && mode == agen_pkg::mode_table_call |=> mem_rd && mem_addr == {10'h001, $past(tix), 1'b0} ##1 mem_rd && mem_addr == {10'h001, $past(tix, 2), 1'b1}; endproperty
  a_tfetch: assert property (p_tfetch) else $error("table fetch");
  property p_tload; take && mode == agen_pkg::mode_table_call |=> busy ##1 busy ##1 !busy && done && instruction_pointer == {$past(mem_rdata), lo_reg}; endproperty
  a_tload: assert property (p_tload) else $error("table load");
endmodule : cpu_address_generation_sva
bind cpu_address_generation cpu_address_generation_sva i_sva (.clk, .resetn, .ce, .start, .mode, .opcode, .short_field,
  .full_address_field, .word_register_index, .mem_rdata, .busy, .done, .eff_addr, .eff_valid, .addr_fault, .reg_word,
  .mem_rd, .mem_addr, .instruction_pointer);

// File: testbench/table_mem.sv
/* table memory model answering the address generator's fetches.
   assumes a combinational read qualified by mem_rd. */
`timescale 1ns/100ps
module table_mem (
  input wire logic        mem_rd,
  input wire logic [15:0] mem_addr,
  output logic [7:0]      mem_rdata
);
  // scrambled address as content so even and odd bytes differ; idle reads show no stale byte
  assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'hc3) : ~mem_addr[7:0];
endmodule : table_mem

// File: testbench/cpu_address_generation_tb.sv
/* self-checking bench for the address generator with the table memory model.
   assumes a 40 MHz clock and synchronous active-low reset. */
`timescale 1ns/100ps
module cpu_address_generation_tb;
  logic            clk, resetn, ce, start, reg_write, busy, done, eff_valid, sel_ram, sel_sfr, addr_fault, mem_rd;
  agen_pkg::mode_t mode;
  logic [7:0]      opcode, short_field, mem_rdata, reg_byte;
  logic [15:0]     full_address_field, reg_wdata, next_ip, eff_addr, reg_word, mem_addr, instruction_pointer, stack_pointer;
  logic [2:0]      byte_register_index;
  logic [1:0]      word_register_index;
  int              err_count, checks;
  cpu_address_generation i_dut (.clk, .resetn, .ce, .start, .mode, .opcode, .short_field, .full_address_field,
    .byte_register_index, .word_register_index, .reg_write, .reg_wdata, .next_ip, .mem_rdata, .busy, .done,
    .eff_addr, .eff_valid, .sel_ram, .sel_sfr, .addr_fault, .reg_byte, .reg_word, .mem_rd, .mem_addr,
    .instruction_pointer, .stack_pointer);
  table_mem i_mem (.mem_rd, .mem_addr, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // one request; returns at the falling edge where the registered answer stands
  task req(input agen_pkg::mode_t m, input logic [7:0] f, input logic w, input logic [15:0] d, input logic [2:0] ix);
    @(negedge clk);
    mode = m;
    short_field = f;
    reg_write = w;
    reg_wdata = d;
    byte_register_index = ix;
    word_register_index = ix[1:0];
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    reg_write = 1'b0;
  endtask : req
  task t_stack;
    req(agen_pkg::mode_push, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(eff_addr, 16'hfefe);
    chk(stack_pointer, 16'hfefe);
    req(agen_pkg::mode_pop, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(eff_addr, 16'hfefe);
    req(agen_pkg::mode_pop, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk({15'h0, addr_fault}, 16'h0000);
    chk(stack_pointer, 16'hff00);
    req(agen_pkg::mode_pop, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk({15'h0, addr_fault}, 16'h0001);
    chk(stack_pointer, 16'hff00);
    req(agen_pkg::mode_push, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(eff_addr, 16'hfeff);
    chk(stack_pointer, 16'hfeff);
    $display("test stack over");
  endtask : t_stack
  task t_regs;
    for (int i = 0; i < 8; i++) req(agen_pkg::mode_reg, 8'h00, 1'b1, 16'(8'h10 + i), 3'(i));
    for (int i = 0; i < 4; i++) begin
      byte_register_index = 3'(2 * i);
      word_register_index = 2'(i);
      @(negedge clk);
      chk(reg_word, {8'(8'h11 + 2 * i), 8'(8'h10 + 2 * i)});
      chk({8'h00, reg_byte}, 16'(8'h10 + 2 * i));
    end
    req(agen_pkg::mode_reg_pair, 8'h00, 1'b1, 16'hfff0, 3'd3);
    byte_register_index = 3'd7;
    @(negedge clk);
    chk({8'h00, reg_byte}, 16'h00ff);
    $display("test registers over");
  endtask : t_regs
  task t_addr;
    logic [7:0] f [7] = '{8'h00, 8'h1f, 8'h20, 8'h31, 8'hcf, 8'hd4, 8'hff};
    foreach (f[i]) begin
      req(agen_pkg::mode_short, f[i], 1'b0, 16'h0000, 3'd0);
      chk(eff_addr, {7'h7f, f[i] < 8'h20, f[i]});
      chk({14'h0, sel_ram, sel_sfr}, {14'h0, f[i] >= 8'h20, f[i] < 8'h20});
      req(agen_pkg::mode_sfr, f[i], 1'b0, 16'h0000, 3'd0);
      chk(eff_addr, {8'hff, f[i]});
      chk({15'h0, addr_fault}, {15'h0, f[i][7:4] == 4'hd});
      req(agen_pkg::mode_short_word, f[i], 1'b0, 16'h0000, 3'd0);
      chk({15'h0, addr_fault}, {15'h0, f[i][0]});
    end
    $display("test operand addresses over");
  endtask : t_addr
  task t_ind;
    full_address_field = 16'hbeef;
    req(agen_pkg::mode_direct, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(eff_addr, 16'hbeef);
    chk({15'h0, eff_valid}, 16'h0001);
    // clock enable low: a request must leave eff_addr frozen
    ce = 1'b0;
    full_address_field = 16'h1111;
    req(agen_pkg::mode_direct, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(eff_addr, 16'hbeef);
    ce = 1'b1;
    req(agen_pkg::mode_reg_pair, 8'h00, 1'b1, 16'h1234, 3'd2);
    req(agen_pkg::mode_ind_second, 8'h00, 1'b0, 16'h0000, 3'd2);
    chk(eff_addr, 16'h1234);
    req(agen_pkg::mode_ind_base, 8'h00, 1'b0, 16'h0000, 3'd3);
    chk(eff_addr, 16'hfff0);
    req(agen_pkg::mode_based, 8'h0f, 1'b0, 16'h0000, 3'd3);
    chk(eff_addr, 16'hffff);
    req(agen_pkg::mode_based, 8'h25, 1'b0, 16'h0000, 3'd3);
    chk(eff_addr, 16'h0015);
    req(agen_pkg::mode_reg_pair, 8'h00, 1'b1, 16'h8a5c, 3'd0);
    req(agen_pkg::mode_reg_jump, 8'h00, 1'b0, 16'h0000, 3'd0);
    chk(instruction_pointer, 16'h8a5c);
    $display("test indirect and jump over");
  endtask : t_ind
  // a direct request held during the fetch must be ignored
  task t_tcall(input logic [4:0] ix);
    logic [7:0] a;
    a = {2'b01, ix, 1'b0};
    @(negedge clk);
    opcode = {2'b00, ix, 1'b1};
    mode = agen_pkg::mode_table_call;
    start = 1'b1;
    @(negedge clk);
    chk({15'h0, busy}, 16'h0001);
    mode = agen_pkg::mode_direct;
    @(negedge clk);
    start = 1'b0;
    chk({15'h0, eff_valid}, 16'h0000);
    @(negedge clk);
    chk({15'h0, done}, 16'h0001);
    chk(instruction_pointer, {a ^ 8'hc2, a ^ 8'hc3});
    $display("test table call over");
  endtask : t_tcall
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    mode = agen_pkg::mode_none;
    opcode = 8'h00;
    short_field = 8'h00;
    full_address_field = 16'h0000;
    byte_register_index = 3'd0;
    word_register_index = 2'd0;
    reg_write = 1'b0;
    reg_wdata = 16'h0000;
    next_ip = 16'h0100;
    err_count = 0;
    checks = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    chk(stack_pointer, 16'hfeff);
    chk(mem_addr, 16'h0040);
    t_stack;
    t_regs;
    t_addr;
    t_ind;
    t_tcall(5'd0);
    t_tcall(5'd31);
    report_and_stop;
  end
  // the tests need about 120 cycles; this span of 2000 cycles is far beyond that
  initial begin
    #50000;
    err_count++;
    report_and_stop;
  end
endmodule : cpu_address_generation_tb
